// *** bench/bus_master_model.sv ***
// Purpose: behavioural two-wire bus master
// Assumes: bit time 8 sys_clk cycles, 400 ns
// Notes: scl idles high outside frames; sda has a pull-up
`timescale 1ns/100ps
module bus_master_model (
	input wire logic sys_clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda_line
);
	logic sda_m = 1'b1;
	initial scl = 1'b1;
	// open drain with pull-up
	assign sda_line = sda_m & ~sda_oe;
	task automatic w(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// start or repeated start
	task automatic start();
		sda_m = 1'b1;
		w(4);
		scl = 1'b1;
		w(4);
		sda_m = 1'b0;
		w(4);
		scl = 1'b0;
	endtask
	task automatic stop();
		w(2);
		sda_m = 1'b0;
		w(2);
		scl = 1'b1;
		w(4);
		sda_m = 1'b1;
		w(4);
	endtask
	// nine bits out, line sampled mid high phase
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			w(2);
			sda_m = d[i];
			w(2);
			scl = 1'b1;
			w(2);
			r[i] = sda_line;
			w(2);
			scl = 1'b0;
		end
	endtask
endmodule // bus_master_model

// *** bench/thermometer_command_decoder_tb_top.sv ***
// Purpose: bench of the thermometer command decoder
// Assumes: NV_CYCLES of 50, select straps 5
// Notes: converter is played by the bench
`timescale 1ns/100ps
module thermometer_command_decoder_tb_top import thermo_pkg::*;;
	logic sys_clk, nrst, scl, sda_line, sda_oe, conv_done, conv_start, converting;
	logic [2:0] select_pins;
	logic [15:0] temp_in, upper_trip_level, lower_trip_level;
	logic [7:0] count_remain_in, count_per_c_in, config_byte;
	logic nonvolatile_busy_bit;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int starts = 0;
	bus_master_model i_master (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl),
		.sda_line(sda_line));
	thermo_cmd_decoder #(.NV_CYCLES(50), .DEV_TYPE(DEV_TYPE_DEFAULT)) i_dut (
		.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(),
		.sda_oe(sda_oe), .select_pins(select_pins), .conv_done(conv_done),
		.temp_in(temp_in), .count_remain_in(count_remain_in),
		.count_per_c_in(count_per_c_in), .conv_start(conv_start), .converting(converting),
		.upper_trip_level(upper_trip_level), .lower_trip_level(lower_trip_level),
		.config_byte(config_byte), .nonvolatile_busy_bit(nonvolatile_busy_bit));
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc++;
		if (conv_start === 1'b1)
			starts++;
		if (cyc == 30000)
		begin
			err_count++;
			results();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic addr(input logic rw, input logic [2:0] sel, input logic ack);
		logic [8:0] r;
		i_master.start();
		i_master.xfer({DEV_TYPE_DEFAULT, sel, rw, 1'b1}, r);
		check(r[0], ack ? 16'h0000 : 16'h0001);
	endtask
	task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
		logic [8:0] r;
		addr(1'b0, 3'h5, 1'b1);
		i_master.xfer({cmd, 1'b1}, r);
		check(r[0], 16'h0000);
		for (int i = n - 1; i >= 0; i--)
		begin
			i_master.xfer({d[8*i +: 8], 1'b1}, r);
			check(r[0], 16'h0000);
		end
		i_master.stop();
		// only setting writes start a cell write
		check(nonvolatile_busy_bit, n > 0 && cmd[7]);
		for (int k = 0; k < 200 && nonvolatile_busy_bit !== 1'b0; k++)
			@(negedge sys_clk);
		check(nonvolatile_busy_bit, 16'h0000);
	endtask
	task automatic rd(input logic [7:0] cmd, input int n, input logic [15:0] exp);
		logic [8:0] r;
		logic [15:0] v;
		v = 16'h0000;
		addr(1'b0, 3'h5, 1'b1);
		i_master.xfer({cmd, 1'b1}, r);
		addr(1'b1, 3'h5, 1'b1);
		for (int i = n - 1; i >= 0; i--)
		begin
			i_master.xfer({8'hFF, i == 0}, r);
			v[8*i +: 8] = r[8:1];
		end
		i_master.stop();
		check(v, exp);
	endtask
	task automatic done(input logic [15:0] t);
		conv_done = 1'b1;
		temp_in = t;
		@(negedge sys_clk);
		conv_done = 1'b0;
		@(negedge sys_clk);
	endtask
	initial
	begin
		nrst = 1'b0;
		conv_done = 1'b0;
		temp_in = 16'h0000;
		count_remain_in = 8'h3C;
		count_per_c_in = 8'h4B;
		select_pins = 3'h5;
		repeat (6) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (4) @(negedge sys_clk);
		check(config_byte, 16'h0080);
		wr(CMD_ACC_UPPER, 2, 16'h2800);
		check(upper_trip_level, 16'h2800);
		rd(CMD_ACC_UPPER, 2, 16'h2800);
		wr(CMD_ACC_LOWER, 2, 16'h0A00);
		check(lower_trip_level, 16'h0A00);
		rd(CMD_ACC_LOWER, 2, 16'h0A00);
		$display("test thresholds done");
		wr(CMD_ACC_CFG, 1, 16'h0002);
		rd(CMD_ACC_CFG, 1, 16'h0082);
		rd(CMD_RD_COUNT, 1, 16'h003C);
		rd(CMD_RD_SLOPE, 1, 16'h004B);
		$display("test config and counts done");
		starts = 0;
		wr(CMD_CONV_GO, 0, 16'h0000);
		check(converting, 16'h0001);
		done(16'h1980);
		done(16'h1900);
		wr(CMD_CONV_HALT, 0, 16'h0000);
		check(converting, 16'h0001);
		done(16'h1880);
		check(converting, 16'h0000);
		check(starts, 16'h0003);
		done(16'h7F00);
		rd(CMD_RD_TEMP, 2, 16'h1880);
		$display("test continuous done");
		wr(CMD_ACC_CFG, 1, 16'h0001);
		wr(CMD_CONV_GO, 0, 16'h0000);
		done(16'h0A80);
		check(converting, 16'h0000);
		check(starts, 16'h0004);
		rd(CMD_RD_TEMP, 2, 16'h0A80);
		$display("test single done");
		wr(8'h55, 1, 16'h00FF);
		check(upper_trip_level, 16'h2800);
		check(config_byte, 16'h0081);
		addr(1'b0, 3'h2, 1'b0);
		i_master.stop();
		$display("test refusals done");
		results();
	end
endmodule // thermometer_command_decoder_tb_top

// *** logic/sync2.sv ***
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // sync2

// *** logic/thermo_cmd_decoder.sv ***
// Purpose: two-wire slave command decoder of a thermometer and thermostat
// Assumes: scl, sda, select pins asynchronous; conversion side on sys_clk
// Notes: sda is open drain, sda_oe high pulls the line low
`timescale 1ns/100ps
module thermo_cmd_decoder import thermo_pkg::*; #(
	parameter int NV_CYCLES = NV_WRITE_CYC,
	parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] select_pins,
	input wire logic conv_done,
	input wire logic [15:0] temp_in,
	input wire logic [7:0] count_remain_in,
	input wire logic [7:0] count_per_c_in,
	output logic conv_start,
	output logic converting,
	output logic [15:0] upper_trip_level,
	output logic [15:0] lower_trip_level,
	output logic [7:0] config_byte,
	output logic nonvolatile_busy_bit
);
	localparam int NVW = $clog2(NV_CYCLES + 1);
	localparam logic [NVW-1:0] NV_LOAD = NVW'(NV_CYCLES);
	localparam logic [NVW-1:0] NV_ZERO = '0;

	// busy must outlast the eight-cycle window its check relies on
	if (NV_CYCLES < 8)
	begin : g_chk
		$error("NV_CYCLES must be at least eight");
	end

	line_t ln;
	line_t ln_q;
	logic [2:0] sel;
	logic scl_rise, scl_fall, start_c, stop_c;

	sync2 #(.W(5)) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.d({scl_in, sda_in, select_pins}),
		.q({ln, sel})
	);

	assign scl_rise = ln.scl & ~ln_q.scl;
	assign scl_fall = ~ln.scl & ln_q.scl;
	assign start_c = ln.scl & ln_q.scl & ln_q.sda & ~ln.sda;
	assign stop_c = ln.scl & ln_q.scl & ~ln_q.sda & ln.sda;

	bus_state_t st_q, st_d;
	logic [3:0] bcnt_q, bcnt_d;
	logic [7:0] sh_q, sh_d, cmd_q, cmd_d, cfg_q, cfg_d, rd_byte, cfg_rd;
	logic rw_q, rw_d, idx_q, idx_d, oe_q, oe_d;
	temp_word_t up_q, up_d, lo_q, lo_d, temp_q, temp_d;
	logic byte_done, go_start, go_stop, nv_kick;
	logic conv_q, conv_d, cont_q, cont_d, start_q, start_d;
	logic [NVW-1:0] nv_q, nv_d;

	assign nonvolatile_busy_bit = (nv_q != NV_ZERO);
	assign byte_done = scl_fall && (bcnt_q == BITS_PER_BYTE);

	always_comb
	begin
		cfg_rd = cfg_q;
		cfg_rd[CFG_DONE] = ~conv_q;
		cfg_rd[CFG_NV_BUSY] = nonvolatile_busy_bit;
		case (cmd_q)
			CMD_RD_TEMP: rd_byte = idx_q ? temp_q.lo : temp_q.hi;
			CMD_ACC_UPPER: rd_byte = idx_q ? up_q.lo : up_q.hi;
			CMD_ACC_LOWER: rd_byte = idx_q ? lo_q.lo : lo_q.hi;
			CMD_ACC_CFG: rd_byte = cfg_rd;
			CMD_RD_COUNT: rd_byte = count_remain_in;
			CMD_RD_SLOPE: rd_byte = count_per_c_in;
			default: rd_byte = IDLE_BYTE;
		endcase
	end

	// bus byte engine
	always_comb
	begin
		st_d = st_q;
		bcnt_d = bcnt_q;
		sh_d = sh_q;
		cmd_d = cmd_q;
		rw_d = rw_q;
		idx_d = idx_q;
		oe_d = oe_q;
		up_d = up_q;
		lo_d = lo_q;
		cfg_d = cfg_q;
		go_start = 1'b0;
		go_stop = 1'b0;
		nv_kick = 1'b0;
		if (start_c)
		begin
			st_d = ST_ADDR;
			bcnt_d = BIT_ZERO;
			oe_d = 1'b0;
		end
		else if (stop_c)
		begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
		end
		else
		begin
			case (st_q)
				ST_ADDR, ST_CMD, ST_WDATA:
				begin
					if (scl_rise && bcnt_q != BITS_PER_BYTE)
					begin
						sh_d = {sh_q[6:0], ln.sda};
						bcnt_d = bcnt_q + BIT_ONE;
					end
					else if (byte_done)
					begin
						oe_d = 1'b1;
						bcnt_d = BIT_ZERO;
						if (st_q == ST_ADDR)
						begin
							if (sh_q[7:4] == DEV_TYPE && sh_q[3:1] == sel)
							begin
								st_d = ST_ADDR_ACK;
								rw_d = sh_q[0];
								idx_d = 1'b0;
							end
							else
							begin
								st_d = ST_IDLE;
								oe_d = 1'b0;
							end
						end
						else if (st_q == ST_CMD)
						begin
							st_d = ST_CMD_ACK;
							cmd_d = sh_q;
							idx_d = 1'b0;
							go_start = (sh_q == CMD_CONV_GO);
							go_stop = (sh_q == CMD_CONV_HALT);
						end
						else
						begin
							st_d = ST_WDATA_ACK;
							idx_d = 1'b1;
							case (cmd_q)
								CMD_ACC_UPPER:
								begin
									nv_kick = 1'b1;
									if (idx_q)
										up_d.lo = sh_q;
									else
										up_d.hi = sh_q;
								end
								CMD_ACC_LOWER:
								begin
									nv_kick = 1'b1;
									if (idx_q)
										lo_d.lo = sh_q;
									else
										lo_d.hi = sh_q;
								end
								CMD_ACC_CFG:
								begin
									if (!idx_q)
									begin
										nv_kick = 1'b1;
										cfg_d = sh_q & CFG_WR_MASK;
									end
								end
								default: nv_kick = 1'b0;
							endcase
						end
					end
				end
				ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK, ST_RACK:
				begin
					if (st_q == ST_RACK && scl_rise && ln.sda)
						st_d = ST_IDLE;
					else if (scl_fall)
					begin
						if ((st_q == ST_ADDR_ACK && rw_q) || st_q == ST_RACK)
						begin
							st_d = ST_RDATA;
							oe_d = ~rd_byte[7];
							sh_d = {rd_byte[6:0], 1'b0};
							bcnt_d = BIT_ONE;
						end
						else
						begin
							oe_d = 1'b0;
							st_d = (st_q == ST_ADDR_ACK) ? ST_CMD : ST_WDATA;
						end
					end
				end
				ST_RDATA:
				begin
					if (scl_fall)
					begin
						if (bcnt_q == BITS_PER_BYTE)
						begin
							oe_d = 1'b0;
							st_d = ST_RACK;
							idx_d = ~idx_q;
						end
						else
						begin
							oe_d = ~sh_q[7];
							sh_d = {sh_q[6:0], 1'b0};
							bcnt_d = bcnt_q + BIT_ONE;
						end
					end
				end
				default: st_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			ln_q <= '1;
			st_q <= ST_IDLE;
			bcnt_q <= BIT_ZERO;
			sh_q <= '0;
			cmd_q <= '0;
			rw_q <= 1'b0;
			idx_q <= 1'b0;
			oe_q <= 1'b0;
			up_q <= WORD_RESET;
			lo_q <= WORD_RESET;
			cfg_q <= CFG_RESET;
		end
		else
		begin
			ln_q <= ln;
			st_q <= st_d;
			bcnt_q <= bcnt_d;
			sh_q <= sh_d;
			cmd_q <= cmd_d;
			rw_q <= rw_d;
			idx_q <= idx_d;
			oe_q <= oe_d;
			up_q <= up_d;
			lo_q <= lo_d;
			cfg_q <= cfg_d;
		end
	end

	// conversion control and nonvolatile timer
	always_comb
	begin
		conv_d = conv_q;
		cont_d = cont_q;
		start_d = 1'b0;
		temp_d = temp_q;
		if (go_stop)
			cont_d = 1'b0;
		if (go_start)
			cont_d = ~cfg_q[CFG_SINGLE];
		if (conv_done && conv_q)
		begin
			temp_d = temp_in;
			if (cont_d)
				start_d = 1'b1;
			else
				conv_d = 1'b0;
		end
		if (go_start && !conv_d)
		begin
			conv_d = 1'b1;
			start_d = 1'b1;
		end
		if (nv_kick)
			nv_d = NV_LOAD;
		else if (nv_q != NV_ZERO)
			nv_d = nv_q - NVW'(1);
		else
			nv_d = nv_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			conv_q <= 1'b0;
			cont_q <= 1'b0;
			start_q <= 1'b0;
			temp_q <= WORD_RESET;
			nv_q <= NV_ZERO;
		end
		else
		begin
			conv_q <= conv_d;
			cont_q <= cont_d;
			start_q <= start_d;
			temp_q <= temp_d;
			nv_q <= nv_d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = oe_q;
	assign conv_start = start_q;
	assign converting = conv_q;
	assign upper_trip_level = up_q;
	assign lower_trip_level = lo_q;
	assign config_byte = cfg_rd;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	upper_write_a: assert property (
		byte_done && st_q == ST_WDATA && cmd_q == CMD_ACC_UPPER && idx_q
		|=> upper_trip_level[7:0] == $past(sh_q) && st_q == ST_WDATA_ACK && sda_oe)
		else $error("upper trip low byte not stored");
	lower_write_a: assert property (
		byte_done && st_q == ST_WDATA && cmd_q == CMD_ACC_LOWER && !idx_q
		|=> lower_trip_level[15:8] == $past(sh_q))
		else $error("lower trip high byte not stored");
	config_write_a: assert property (
		byte_done && st_q == ST_WDATA && cmd_q == CMD_ACC_CFG && !idx_q
		|=> cfg_q == ($past(sh_q) & CFG_WR_MASK) ##1 nonvolatile_busy_bit)
		else $error("config byte not stored");
	temp_hold_a: assert property (
		conv_done && converting |=> upper_trip_level == $past(upper_trip_level)
		&& temp_q == $past(temp_in))
		else $error("conversion result not captured");
	start_conv_a: assert property (
		go_start && !converting |=> conv_start && converting ##1 !conv_start)
		else $error("start command did not start conversion");
	stop_finish_a: assert property (
		go_stop && converting && !conv_done |=> converting && !cont_q)
		else $error("stop aborted the running conversion");
	nv_busy_a: assert property (
		nv_kick |=> nonvolatile_busy_bit [*8])
		else $error("nonvolatile busy dropped early");
	addr_nomatch_a: assert property (
		byte_done && st_q == ST_ADDR && (sh_q[7:4] != DEV_TYPE || sh_q[3:1] != sel)
		&& !start_c && !stop_c
		|=> st_q == ST_IDLE && !sda_oe)
		else $error("foreign address acknowledged");
	unknown_cmd_a: assert property (
		byte_done && st_q == ST_WDATA && cmd_q != CMD_ACC_UPPER && !start_c
		&& cmd_q != CMD_ACC_LOWER && cmd_q != CMD_ACC_CFG
		|=> $stable(up_q) && $stable(lo_q) && $stable(cfg_q) && sda_oe)
		else $error("unknown command changed state");
	chain_start_a: assert property (
		start_c |=> st_q == ST_ADDR && bcnt_q == BIT_ZERO && !sda_oe)
		else $error("repeated start not accepted");

	read_temp_c: cover property (st_q == ST_RDATA && cmd_q == CMD_RD_TEMP && idx_q);
	conv_go_c: cover property (go_start ##[1:1000] conv_start);
	nv_write_c: cover property (nv_kick);
	cont_conv_c: cover property (conv_done && cont_q ##1 conv_start);
endmodule // thermo_cmd_decoder

// *** logic/thermo_pkg.sv ***
// Purpose: shared constants and types of the thermometer command decoder
// Assumes: one 20 MHz system clock
// Notes: command codes, config layout, timing
package thermo_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int NV_WRITE_MS = 10;
	localparam int NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);
	// device type code value is arbitrary
	localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
	localparam logic [7:0] CMD_ACC_UPPER = 8'hA1;
	localparam logic [7:0] CMD_ACC_LOWER = 8'hA2;
	localparam logic [7:0] CMD_ACC_CFG = 8'hAC;
	localparam logic [7:0] CMD_RD_COUNT = 8'hA8;
	localparam logic [7:0] CMD_RD_SLOPE = 8'hA9;
	localparam logic [7:0] CMD_RD_TEMP = 8'hAA;
	localparam logic [7:0] CMD_CONV_GO = 8'hEE;
	localparam logic [7:0] CMD_CONV_HALT = 8'h22;
	localparam int CFG_DONE = 7;
	localparam int CFG_NV_BUSY = 4;
	localparam int CFG_SINGLE = 0;
	localparam logic [7:0] CFG_WR_MASK = 8'h03;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam logic [3:0] BIT_ZERO = 4'h0;

	typedef struct packed {
		logic scl;
		logic sda;
	} line_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} temp_word_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_CMD,
		ST_CMD_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RACK
	} bus_state_t;
endpackage
